// >>> src/mem_hw_auto_init.sv
// Memory auto-initialization block with AXI4-Lite register access
`timescale 1ns/1ps
module mem_hw_auto_init
    import mem_init_pkg::*;
(
    input  wire logic                            ref_clk,
    input  wire logic                            sys_rst,
    input  wire logic [7:0]                      s_axi_awaddr,
    input  wire logic                            s_axi_awvalid,
    output logic                                 s_axi_awready,
    input  wire logic [31:0]                     s_axi_wdata,
    input  wire logic [3:0]                      s_axi_wstrb,
    input  wire logic                            s_axi_wvalid,
    output logic                                 s_axi_wready,
    output logic [1:0]                           s_axi_bresp,
    output logic                                 s_axi_bvalid,
    input  wire logic                            s_axi_bready,
    input  wire logic [7:0]                      s_axi_araddr,
    input  wire logic                            s_axi_arvalid,
    output logic                                 s_axi_arready,
    output logic [31:0]                          s_axi_rdata,
    output logic [1:0]                           s_axi_rresp,
    output logic                                 s_axi_rvalid,
    input  wire logic                            s_axi_rready,
    input  wire logic [mem_init_pkg::NUM_SPORTS-1:0] sport_in_reset,
    output logic [31:0]                          mem_sel,
    output logic [mem_init_pkg::ADDR_WIDTH-1:0]  mem_addr,
    output logic                                 mem_we,
    output logic                                 mem_check_odd,
    output logic                                 ecc_we,
    output logic [mem_init_pkg::DOMAIN_WIDTH-1:0] tcm_domain
);
    import mem_init_pkg::*;

    mem_init_if link ();

    // ========================================
    // Register state
    logic [KEY_WIDTH-1:0]    key, next_key;
    logic [31:0]             select, next_select;
    logic                    done_flag, next_done_flag;
    logic [DOMAIN_WIDTH-1:0] domain, next_domain;
    logic                    odd, next_odd;
    logic                    start, next_start;
    // Bus state
    logic                    aw_full, next_aw_full;
    logic                    w_full, next_w_full;
    logic [7:0]              aw_q, next_aw_q;
    logic [31:0]             wd_q, next_wd_q;
    logic [3:0]              ws_q, next_ws_q;
    logic                    next_awready, next_wready, next_arready;
    logic                    next_bvalid, next_rvalid;
    logic [1:0]              next_bresp, next_rresp;
    logic [31:0]             next_rdata;
    logic                    do_write;
    logic [31:0]             wmask;

    // ========================================
    // Write channel and register updates
    always_comb begin
        next_aw_full   = aw_full;
        next_w_full    = w_full;
        next_aw_q      = aw_q;
        next_wd_q      = wd_q;
        next_ws_q      = ws_q;
        next_bvalid    = s_axi_bvalid;
        next_bresp     = s_axi_bresp;
        next_key       = key;
        next_select    = select;
        next_domain    = domain;
        next_odd       = odd;
        next_start     = 1'b0;
        next_done_flag = done_flag;
        wmask = {{8{ws_q[3]}}, {8{ws_q[2]}}, {8{ws_q[1]}}, {8{ws_q[0]}}};
        if (s_axi_awvalid && s_axi_awready) begin
            next_aw_full = 1'b1;
            next_aw_q    = s_axi_awaddr;
        end
        if (s_axi_wvalid && s_axi_wready) begin
            next_w_full = 1'b1;
            next_wd_q   = s_axi_wdata;
            next_ws_q   = s_axi_wstrb;
        end
        if (s_axi_bvalid && s_axi_bready) begin
            next_bvalid = 1'b0;
        end
        do_write = aw_full && w_full && !s_axi_bvalid;
        if (do_write) begin
            next_aw_full = 1'b0;
            next_w_full  = 1'b0;
            next_bvalid  = 1'b1;
            next_bresp   = RESP_OKAY;
            unique case ({aw_q[7:2], 2'b00})
                GLOBAL_CTRL_OFFS: if (ws_q[0]) begin
                    next_key = wd_q[KEY_WIDTH-1:0];
                    // Writes while busy cannot restart a running sweep
                    next_start = (wd_q[KEY_WIDTH-1:0] == KEY_ENABLE) && !link.busy;
                end
                SELECT_OFFS: if (!link.busy) begin
                    next_select = (select & ~wmask) | (wd_q & wmask);
                end
                STATUS_OFFS: if (ws_q[0] && wd_q[DONE_BIT]) begin
                    next_done_flag = 1'b0;                     // Write one to clear
                end
                WRAP_CTRL_OFFS: if (ws_q[0]) begin
                    next_domain = wd_q[DOMAIN_WIDTH-1:0];
                    next_odd    = wd_q[ODD_BIT];
                end
                default: next_bresp = RESP_DECERR;
            endcase
        end
        // Completion set wins over a same-cycle clear
        if (link.done) begin
            next_done_flag = 1'b1;
        end
        next_awready = !next_aw_full && !next_bvalid;
        next_wready  = !next_w_full && !next_bvalid;
    end

    // ========================================
    // Read channel
    always_comb begin
        next_rvalid = s_axi_rvalid;
        next_rdata  = s_axi_rdata;
        next_rresp  = s_axi_rresp;
        if (s_axi_rvalid && s_axi_rready) begin
            next_rvalid = 1'b0;
        end
        if (s_axi_arvalid && s_axi_arready) begin
            next_rvalid = 1'b1;
            next_rresp  = RESP_OKAY;
            next_rdata  = '0;
            unique case ({s_axi_araddr[7:2], 2'b00})
                GLOBAL_CTRL_OFFS: next_rdata[KEY_WIDTH-1:0] = key;
                SELECT_OFFS:      next_rdata = select;
                STATUS_OFFS: begin
                    next_rdata[DONE_BIT] = done_flag;
                    next_rdata[BUSY_BIT] = link.busy;
                end
                WRAP_CTRL_OFFS: begin
                    next_rdata[DOMAIN_WIDTH-1:0] = domain;
                    next_rdata[ODD_BIT]          = odd;
                end
                default: next_rresp = RESP_DECERR;
            endcase
        end
        next_arready = !next_rvalid;
    end

    // Registers of both channels and the control file
    always_ff @(posedge ref_clk or posedge sys_rst) begin
        if (sys_rst) begin
            aw_full       <= 1'b0;
            w_full        <= 1'b0;
            aw_q          <= '0;
            wd_q          <= '0;
            ws_q          <= '0;
            s_axi_awready <= 1'b0;
            s_axi_wready  <= 1'b0;
            s_axi_bvalid  <= 1'b0;
            s_axi_bresp   <= RESP_OKAY;
            s_axi_arready <= 1'b0;
            s_axi_rvalid  <= 1'b0;
            s_axi_rdata   <= '0;
            s_axi_rresp   <= RESP_OKAY;
            key           <= KEY_RESET;
            select        <= SELECT_RESET;
            done_flag     <= 1'b0;
            domain        <= DOMAIN_RESET;
            odd           <= 1'b0;
            start         <= 1'b0;
        end else begin
            aw_full       <= next_aw_full;
            w_full        <= next_w_full;
            aw_q          <= next_aw_q;
            wd_q          <= next_wd_q;
            ws_q          <= next_ws_q;
            s_axi_awready <= next_awready;
            s_axi_wready  <= next_wready;
            s_axi_bvalid  <= next_bvalid;
            s_axi_bresp   <= next_bresp;
            s_axi_arready <= next_arready;
            s_axi_rvalid  <= next_rvalid;
            s_axi_rdata   <= next_rdata;
            s_axi_rresp   <= next_rresp;
            key           <= next_key;
            select        <= next_select;
            done_flag     <= next_done_flag;
            domain        <= next_domain;
            odd           <= next_odd;
            start         <= next_start;
        end
    end

    // ========================================
    // Engine and memory-side ports
    assign link.start          = start;
    assign link.select         = select;
    assign link.sport_in_reset = sport_in_reset;

    mem_init_engine engine (
        .ref_clk (ref_clk),
        .sys_rst (sys_rst),
        .bus     (link)
    );

    // Memory strobes re-timed so every port leaves a flip-flop; costs one cycle
    // Zero data with zero ECC is a valid codeword; parity polarity follows odd
    always_ff @(posedge ref_clk or posedge sys_rst) begin
        if (sys_rst) begin
            mem_sel  <= '0;
            mem_addr <= '0;
            mem_we   <= 1'b0;
            ecc_we   <= 1'b0;
        end else begin
            mem_sel  <= link.mem_sel;
            mem_addr <= link.mem_addr;
            mem_we   <= link.mem_we;
            ecc_we   <= link.mem_we & link.mem_sel[TCM_BIT];
        end
    end
    assign mem_check_odd = odd;
    assign tcm_domain    = domain;
endmodule

// >>> src/mem_init_engine.sv
// Sequencer that walks every selected RAM not held in port reset with a zero pattern
`timescale 1ns/1ps
module mem_init_engine
    import mem_init_pkg::*;
(
    input  wire logic ref_clk,
    input  wire logic sys_rst,
    mem_init_if.engine bus
);
    import mem_init_pkg::*;

    // ========================================
    // Pending work
    localparam logic [31:0] ONE = 32'h0000_0001;
    engine_state_t         state, next_state;
    logic [31:0]           sys_pend, next_sys_pend;
    logic [31:0]           loc_pend, next_loc_pend;
    logic                  sys_run, next_sys_run;
    logic [31:0]           cur, next_cur;
    logic [ADDR_WIDTH-1:0] addr, next_addr;
    logic                  we, next_we;
    logic                  done, next_done;
    logic [NUM_SPORTS-1:0] rst_prev;
    logic [31:0]           released;
    logic [31:0]           in_reset;
    logic [31:0]           pend;

    // Map serial port reset levels onto their select bits
    always_comb begin
        released = '0;
        in_reset = '0;
        released[SPORT_ONE_BIT]   = rst_prev[0] & ~bus.sport_in_reset[0];
        released[SPORT_THREE_BIT] = rst_prev[1] & ~bus.sport_in_reset[1];
        released[SPORT_FIVE_BIT]  = rst_prev[2] & ~bus.sport_in_reset[2];
        in_reset[SPORT_ONE_BIT]   = bus.sport_in_reset[0];
        in_reset[SPORT_THREE_BIT] = bus.sport_in_reset[1];
        in_reset[SPORT_FIVE_BIT]  = bus.sport_in_reset[2];
        pend = sys_pend | loc_pend;
    end

    // Next state: one word per cycle, lowest pending memory first
    always_comb begin
        next_state    = state;
        next_sys_pend = sys_pend;
        next_loc_pend = loc_pend | released;
        next_sys_run  = sys_run;
        next_cur      = cur;
        next_addr     = addr;
        next_we       = 1'b0;
        next_done     = 1'b0;
        unique case (state)
            ENG_IDLE: begin
                if (bus.start) begin
                    // Ports still held in local reset cannot take the walk
                    next_sys_pend = bus.select & ~in_reset;
                    next_sys_run  = 1'b1;
                end else if (pend != '0) begin
                    next_cur   = pend & (~pend + ONE);
                    next_addr  = '0;
                    next_we    = 1'b1;
                    next_state = ENG_WALK;
                end else if (sys_run) begin
                    next_sys_run = 1'b0;
                    next_done    = 1'b1;
                end
            end
            ENG_WALK: begin
                if (addr == LAST_WORD) begin
                    next_sys_pend = sys_pend & ~cur;
                    next_loc_pend = (loc_pend & ~cur) | released;
                    next_cur      = '0;
                    next_state    = ENG_IDLE;
                end else begin
                    next_addr = addr + 1'b1;
                    next_we   = 1'b1;
                end
                // A local port walk must not swallow a software start
                if (bus.start) begin
                    next_sys_pend = bus.select & ~in_reset;
                    next_sys_run  = 1'b1;
                end
            end
        endcase
    end

    // Registers
    always_ff @(posedge ref_clk or posedge sys_rst) begin
        if (sys_rst) begin
            state    <= ENG_IDLE;
            sys_pend <= '0;
            loc_pend <= '0;
            sys_run  <= 1'b0;
            cur      <= '0;
            addr     <= '0;
            we       <= 1'b0;
            done     <= 1'b0;
            rst_prev <= '0;
        end else begin
            state    <= next_state;
            sys_pend <= next_sys_pend;
            loc_pend <= next_loc_pend;
            sys_run  <= next_sys_run;
            cur      <= next_cur;
            addr     <= next_addr;
            we       <= next_we;
            done     <= next_done;
            rst_prev <= bus.sport_in_reset;
        end
    end

    assign bus.busy     = sys_run;
    assign bus.done     = done;
    assign bus.mem_sel  = cur;
    assign bus.mem_addr = addr;
    assign bus.mem_we   = we;
endmodule

// >>> src/mem_init_if.sv
// Carrier between the register front end and the init engine
`timescale 1ns/1ps
interface mem_init_if;
    import mem_init_pkg::*;
    logic                       start;
    logic [31:0]                select;
    logic [NUM_SPORTS-1:0]      sport_in_reset;
    logic                       busy;
    logic                       done;
    logic [31:0]                mem_sel;
    logic [ADDR_WIDTH-1:0]      mem_addr;
    logic                       mem_we;
    modport front  (output start, output select, output sport_in_reset,
                    input busy, input done, input mem_sel, input mem_addr, input mem_we);
    modport engine (input start, input select, input sport_in_reset,
                    output busy, output done, output mem_sel, output mem_addr, output mem_we);
endinterface

// >>> src/mem_init_pkg.sv
// Constants and types shared by the memory auto-initialization block
package mem_init_pkg;
    // ========================================
    // Register map (byte addresses)
    localparam logic [7:0]  GLOBAL_CTRL_OFFS = 8'h00;
    localparam logic [7:0]  SELECT_OFFS      = 8'h04;
    localparam logic [7:0]  STATUS_OFFS      = 8'h08;
    localparam logic [7:0]  WRAP_CTRL_OFFS   = 8'h0C;
    // ========================================
    // Field layouts and reset values
    localparam int          KEY_WIDTH        = 4;
    localparam logic [3:0]  KEY_ENABLE       = 4'hA;
    localparam logic [3:0]  KEY_RESET        = 4'h5;
    localparam logic [31:0] SELECT_RESET     = 32'h0000_0000;
    localparam int          DONE_BIT         = 0;
    localparam int          BUSY_BIT         = 1;
    localparam int          DOMAIN_WIDTH     = 2;
    localparam logic [1:0]  DOMAIN_RESET     = 2'b11;
    localparam int          ODD_BIT          = 2;
    // ========================================
    // Memory map of select bits
    localparam int          TCM_BIT          = 0;
    localparam int          DMA_BIT          = 1;
    localparam int          VECTOR_BIT       = 2;
    localparam int          SPORT_ONE_BIT    = 7;
    localparam int          SPORT_THREE_BIT  = 11;
    localparam int          SPORT_FIVE_BIT   = 12;
    localparam int          NUM_SPORTS       = 3;
    localparam int          ADDR_WIDTH       = 10;
    localparam logic [9:0]  LAST_WORD        = 10'h3FF;
    // ========================================
    // AXI responses
    localparam logic [1:0]  RESP_OKAY        = 2'b00;
    localparam logic [1:0]  RESP_DECERR      = 2'b11;
    typedef enum logic [0:0] {
        ENG_IDLE = 1'b0,
        ENG_WALK = 1'b1
    } engine_state_t;
endpackage

// >>> test/mem_hw_auto_init_tb.sv
// Self-checking bench for the memory auto-initialization block
`timescale 1ns/1ps
module mem_hw_auto_init_tb;
    import mem_init_pkg::*;
    logic                  ref_clk, sys_rst, clear;
    logic [7:0]            s_axi_awaddr, s_axi_araddr;
    logic [31:0]           s_axi_wdata, s_axi_rdata, mem_sel, v, sel;
    logic                  s_axi_awvalid, s_axi_awready, s_axi_wvalid, s_axi_wready;
    logic                  s_axi_bvalid, s_axi_bready, s_axi_arvalid, s_axi_arready;
    logic                  s_axi_rvalid, s_axi_rready, mem_we, mem_check_odd, ecc_we;
    logic [1:0]            s_axi_bresp, s_axi_rresp, tcm_domain, r;
    logic [NUM_SPORTS-1:0] sport_in_reset;
    logic [ADDR_WIDTH-1:0] mem_addr;
    int                    fails, comparisons, n;
    localparam int         WORDS = int'(LAST_WORD) + 1;
    // ========================================
    // Design and far-side model
    mem_hw_auto_init dut_u (.ref_clk(ref_clk), .sys_rst(sys_rst),
        .s_axi_awaddr(s_axi_awaddr), .s_axi_awvalid(s_axi_awvalid), .s_axi_awready(s_axi_awready),
        .s_axi_wdata(s_axi_wdata), .s_axi_wstrb(4'hF), .s_axi_wvalid(s_axi_wvalid),
        .s_axi_wready(s_axi_wready), .s_axi_bresp(s_axi_bresp), .s_axi_bvalid(s_axi_bvalid),
        .s_axi_bready(s_axi_bready), .s_axi_araddr(s_axi_araddr), .s_axi_arvalid(s_axi_arvalid),
        .s_axi_arready(s_axi_arready), .s_axi_rdata(s_axi_rdata), .s_axi_rresp(s_axi_rresp),
        .s_axi_rvalid(s_axi_rvalid), .s_axi_rready(s_axi_rready), .sport_in_reset(sport_in_reset),
        .mem_sel(mem_sel), .mem_addr(mem_addr), .mem_we(mem_we), .mem_check_odd(mem_check_odd),
        .ecc_we(ecc_we), .tcm_domain(tcm_domain));
    ram_array_model ram_u (.ref_clk(ref_clk), .clear(clear), .mem_sel(mem_sel),
        .mem_addr(mem_addr), .mem_we(mem_we), .ecc_we(ecc_we));
    // Free-running 40 MHz clock
    always #12.5 ref_clk = ~ref_clk;
    // ========================================
    // Report, compare and bus tasks
    task automatic stop_test;
        $display("comparisons %0d fails %0d", comparisons, fails);
        if (fails == 0 && comparisons > 0) begin
            $display("All tests passed");
        end else begin
            $display("Some tests failed");
        end
        $finish;
    endtask
    task automatic check(input string what, input logic [31:0] exp, input logic [31:0] got);
        comparisons++;
        if (got !== exp) begin
            fails++;
            $display("wrong value %s expected %h seen %h", what, exp, got);
        end
    endtask
    // Bounded wait step; a hang counts as a mismatch
    task automatic tick;
        @(posedge ref_clk);
        n++;
        if (n > 8000) begin
            fails++;
            $display("wrong value wait expected answer seen none");
            stop_test();
        end
    endtask
    // Address and data offered together, each dropped once taken
    task automatic wr(input logic [7:0] a, input logic [31:0] d, output logic [1:0] resp);
        logic aw_ok, w_ok;
        aw_ok = 1'b0;
        w_ok = 1'b0;
        n = 0;
        s_axi_awaddr <= a;
        s_axi_awvalid <= 1'b1;
        s_axi_wdata <= d;
        s_axi_wvalid <= 1'b1;
        while (!(aw_ok && w_ok)) begin
            tick();
            if (!aw_ok && s_axi_awready === 1'b1) begin
                aw_ok = 1'b1;
                s_axi_awvalid <= 1'b0;
            end
            if (!w_ok && s_axi_wready === 1'b1) begin
                w_ok = 1'b1;
                s_axi_wvalid <= 1'b0;
            end
        end
        do tick(); while (s_axi_bvalid !== 1'b1);
        resp = s_axi_bresp;
    endtask
    task automatic rd(input logic [7:0] a, output logic [31:0] d, output logic [1:0] resp);
        n = 0;
        s_axi_araddr <= a;
        s_axi_arvalid <= 1'b1;
        do tick(); while (s_axi_arready !== 1'b1);
        s_axi_arvalid <= 1'b0;
        do tick(); while (s_axi_rvalid !== 1'b1);
        d = s_axi_rdata;
        resp = s_axi_rresp;
    endtask
    // Start the engine and poll status until the done flag shows
    task automatic run_init;
        int k;
        wr(GLOBAL_CTRL_OFFS, {28'h000_0000, KEY_ENABLE}, r);
        k = 0;
        do begin
            rd(STATUS_OFFS, v, r);
            k++;
        end while (v[DONE_BIT] !== 1'b1 && k < 4000);
        check("status after run", 32'h0000_0001, v);
        // A sweep that never finishes ends the run here
        if (v[DONE_BIT] !== 1'b1) stop_test();
    endtask
    // ========================================
    // Main sequence
    initial begin
        ref_clk = 1'b0;
        sys_rst = 1'b1;
        clear = 1'b0;
        {s_axi_awaddr, s_axi_araddr, s_axi_wdata} = '0;
        {s_axi_awvalid, s_axi_wvalid, s_axi_arvalid} = '0;
        s_axi_bready = 1'b1;
        s_axi_rready = 1'b1;
        sport_in_reset = 3'h7;
        fails = 0;
        comparisons = 0;
        repeat (12) @(posedge ref_clk);
        sys_rst <= 1'b0;
        @(posedge ref_clk);
        // Reset values and unmapped offsets
        rd(SELECT_OFFS, v, r);
        check("select reset", SELECT_RESET, v);
        rd(WRAP_CTRL_OFFS, v, r);
        check("wrap reset", {30'h0000_0000, DOMAIN_RESET}, v);
        rd(GLOBAL_CTRL_OFFS, v, r);
        check("ctrl reset", {28'h000_0000, KEY_RESET}, v);
        rd(8'h10, v, r);
        check("unmapped read", {30'h0000_0000, RESP_DECERR}, {30'h0000_0000, r});
        wr(8'h14, 32'h0000_00FF, r);
        check("unmapped write", {30'h0000_0000, RESP_DECERR}, {30'h0000_0000, r});
        // Releasing port five starts its own local init
        sport_in_reset <= 3'h3;
        n = 0;
        while (ram_u.word_count[SPORT_FIVE_BIT] < WORDS) tick();
        check("port five local words", WORDS, ram_u.word_count[SPORT_FIVE_BIT]);
        repeat (3) @(posedge ref_clk);
        clear <= 1'b1;
        @(posedge ref_clk);
        clear <= 1'b0;
        // Select cpu ram, dma, vectors, port one (held) and port five
        sel = (32'h0000_0001 << TCM_BIT) | (32'h0000_0001 << DMA_BIT) |
              (32'h0000_0001 << VECTOR_BIT) | (32'h0000_0001 << SPORT_ONE_BIT) |
              (32'h0000_0001 << SPORT_FIVE_BIT);
        wr(SELECT_OFFS, sel, r);
        wr(WRAP_CTRL_OFFS, 32'h0000_0006, r);
        check("domain", 32'h0000_0002, {30'h0000_0000, tcm_domain});
        check("odd parity", 32'h0000_0001, {31'h0000_0000, mem_check_odd});
        // A wrong key must not start anything
        wr(GLOBAL_CTRL_OFFS, 32'h0000_0003, r);
        rd(STATUS_OFFS, v, r);
        check("status no key", 32'h0000_0000, v);
        check("words no key", 32'h0000_0000, ram_u.word_count[TCM_BIT]);
        run_init();
        // Held port skipped; unselected arrays untouched
        for (int i = 0; i < 32; i++) begin
            v = (sel[i] && i != SPORT_ONE_BIT) ? WORDS : 0;
            check("words per memory", v, ram_u.word_count[i]);
        end
        check("ecc words", WORDS, ram_u.ecc_count);
        wr(STATUS_OFFS, 32'h0000_0001, r);
        rd(STATUS_OFFS, v, r);
        check("status cleared", 32'h0000_0000, v);
        // Engine back in idle: a second start walks only the new choice
        wr(SELECT_OFFS, 32'h0000_0001 << DMA_BIT, r);
        rd(SELECT_OFFS, v, r);
        check("select readback", 32'h0000_0001 << DMA_BIT, v);
        run_init();
        check("dma twice", 2 * WORDS, ram_u.word_count[DMA_BIT]);
        check("cpu ram once", WORDS, ram_u.word_count[TCM_BIT]);
        stop_test();
    end
endmodule

// >>> test/mem_init_checker.sv
// Port-level assertions for the memory auto-initialization block
`timescale 1ns/1ps
module mem_init_checker
    import mem_init_pkg::*;
(
    input wire logic                              ref_clk,
    input wire logic                              sys_rst,
    input wire logic                              s_axi_arvalid,
    input wire logic                              s_axi_arready,
    input wire logic                              s_axi_rvalid,
    input wire logic                              s_axi_bvalid,
    input wire logic                              s_axi_bready,
    input wire logic [mem_init_pkg::NUM_SPORTS-1:0] sport_in_reset,
    input wire logic [31:0]                       mem_sel,
    input wire logic [mem_init_pkg::ADDR_WIDTH-1:0] mem_addr,
    input wire logic                              mem_we,
    input wire logic                              ecc_we
);
    // ========================================
    // Clocking and word-run sequences
    default clocking cb @(posedge ref_clk); endclocking
    default disable iff (sys_rst);
    sequence last_word_s;
        mem_we && mem_addr == LAST_WORD;
    endsequence
    sequence mid_word_s;
        mem_we && mem_addr != LAST_WORD;
    endsequence
    // ========================================
    // Assertions
    ecc_pair_a: assert property (ecc_we == (mem_we && mem_sel[TCM_BIT]))
        else $error("ecc strobe not tied to cpu ram writes");
    sel_onehot_a: assert property (mem_we |-> $onehot(mem_sel))
        else $error("more than one memory written at once");
    run_start_a: assert property ($rose(mem_we) |-> mem_addr == 10'h000)
        else $error("memory run does not start at word zero");
    addr_step_a: assert property (mid_word_s |=> mem_we && $stable(mem_sel) &&
        mem_addr == $past(mem_addr) + 10'h001) else $error("memory run skips a word");
    run_gap_a: assert property (last_word_s |=> !mem_we)
        else $error("no gap after last word");
    port_skip_a: assert property (mem_we |->
        (mem_sel[NUM_SPORTS+9:SPORT_ONE_BIT] == 6'h00 ||
        !((mem_sel[SPORT_ONE_BIT] && sport_in_reset[0]) ||
          (mem_sel[SPORT_THREE_BIT] && sport_in_reset[1]) ||
          (mem_sel[SPORT_FIVE_BIT] && sport_in_reset[2])))) else $error("port in reset written");
    read_answer_a: assert property (s_axi_arvalid && s_axi_arready |=> s_axi_rvalid)
        else $error("read answer late");
    one_resp_a: assert property (s_axi_bvalid && s_axi_bready |=> !s_axi_bvalid)
        else $error("write response repeated");
endmodule
bind mem_hw_auto_init mem_init_checker chk_u (
    .ref_clk(ref_clk), .sys_rst(sys_rst), .s_axi_arvalid(s_axi_arvalid),
    .s_axi_arready(s_axi_arready), .s_axi_rvalid(s_axi_rvalid), .s_axi_bvalid(s_axi_bvalid),
    .s_axi_bready(s_axi_bready), .sport_in_reset(sport_in_reset), .mem_sel(mem_sel),
    .mem_addr(mem_addr), .mem_we(mem_we), .ecc_we(ecc_we));

// >>> test/ram_array_model.sv
// Behavioural model of the on-chip RAM arrays and their check storage
`timescale 1ns/1ps
module ram_array_model
    import mem_init_pkg::*;
(
    input wire logic                              ref_clk,
    input wire logic                              clear,
    input wire logic [31:0]                       mem_sel,
    input wire logic [mem_init_pkg::ADDR_WIDTH-1:0] mem_addr,
    input wire logic                              mem_we,
    input wire logic                              ecc_we
);
    int word_count [32];
    int ecc_count;
    // ========================================
    // Count stored words per array, ECC words beside the cpu ram
    always @(posedge ref_clk) begin
        for (int i = 0; i < 32; i++) begin
            if (clear) word_count[i] = 0;
            else if (mem_we && mem_sel[i]) word_count[i]++;
        end
        if (clear) ecc_count = 0;
        else if (ecc_we) ecc_count++;
    end
endmodule
